// file: hw/crc_pkg.sv
// Package for the configuration restart and initialization controller.
// Assumes a single 20 MHz clock domain.
package crc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int REQ_MIN_LOW_NS = 500;
	localparam int REQ_MIN_CYC =
		(REQ_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESTART_MAX_US = 230;
	localparam int RESTART_CYC = (RESTART_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES = 3192;
	localparam int OSC_DIV = 2;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_CONFIG,
		ST_ERROR,
		ST_INIT,
		ST_USER
	} crc_state_e;

	// Options captured from the configuration stream
	typedef struct packed {
		logic auto_restart;
		logic user_clk_en;
		logic init_out_en;
	} crc_opts_s;

	// Open-drain pins toward the host
	typedef struct packed {
		logic status_oe;
		logic done_oe;
		logic init_oe;
	} crc_pins_s;
endpackage : crc_pkg

// file: hw/crc_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to the local clock.
`timescale 1ns/1ps
module crc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= INIT;
			q_o <= INIT;
		end
		else
		begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule : crc_sync

// file: hw/crc_ctrl.sv
// Configuration restart, error recovery and initialization controller.
// Assumes host pulls open-drain lines up; frame and done events come from
// the configuration data path on the same clock.
`timescale 1ns/1ps
module crc_ctrl
	import crc_pkg::*;
#(
	parameter int RESTART_CYCLES = RESTART_CYC,
	parameter int INIT_COUNT = INIT_CYCLES
)(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CONFIG_REQUEST_N_I,
	input wire logic STATUS_N_I,
	input wire logic CONFIG_DONE_I,
	input wire logic USER_INIT_CLOCK_I,
	input wire logic FRAME_VALID_I,
	input wire logic FRAME_ERROR_I,
	input wire logic DATA_COMPLETE_I,
	input wire crc_pkg::crc_opts_s OPTS_I,
	output logic STATUS_N_O,
	output logic STATUS_N_OE_O,
	output logic CONFIG_DONE_O,
	output logic CONFIG_DONE_OE_O,
	output logic INIT_COMPLETE_O,
	output logic INIT_COMPLETE_OE_O,
	output logic IO_ENABLE_O,
	output logic CONFIG_ACTIVE_O,
	output logic USER_MODE_O
);
	import crc_pkg::*;

	crc_state_e state_reg;
	crc_opts_s opts_reg;
	crc_pins_s pins;
	logic [2:0] pins_sync;
	logic req_n_s;
	logic status_s;
	logic done_s;
	logic uclk_s;
	logic uclk_d_reg;
	logic [CNT_W-1:0] tmo_reg;
	logic [CNT_W-1:0] init_reg;
	logic [CNT_W-1:0] osc_reg;
	logic osc_tick;
	logic init_tick;
	logic first_frame_reg;
	logic init_low_reg;
	logic first_hit;

	// Counters run from zero, so the last count is the limit less one
	function automatic logic cnt_last(input logic [CNT_W-1:0] cnt,
		input int lim);
		return cnt == CNT_W'(lim - 1);
	endfunction : cnt_last

	// Options and init pin both key off the first accepted frame
	assign first_hit = (state_reg == ST_CONFIG) && FRAME_VALID_I &&
		first_frame_reg;

	// Pins sample through two flops; user clock kept apart
	crc_sync #(.W(3), .INIT(3'h7)) u_sync_pins (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.d_i({CONFIG_REQUEST_N_I, STATUS_N_I, CONFIG_DONE_I}),
		.q_o(pins_sync)
	);
	crc_sync #(.W(1), .INIT(1'h0)) u_sync_uclk (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.d_i(USER_INIT_CLOCK_I),
		.q_o(uclk_s)
	);
	assign req_n_s = pins_sync[2];
	assign status_s = pins_sync[1];
	assign done_s = pins_sync[0];

	// Oscillator stand-in: divided enable
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I || osc_tick)
			osc_reg <= CNT_ZERO;
		else
			osc_reg <= osc_reg + CNT_ONE;
	end
	assign osc_tick = cnt_last(osc_reg, OSC_DIV);

	always_ff @(posedge MCLK_I)
	begin
		if (RST_I)
			uclk_d_reg <= 1'b0;
		else
			uclk_d_reg <= uclk_s;
	end

	// Rising edge of user clock only when option on
	assign init_tick = opts_reg.user_clk_en ? (uclk_s & ~uclk_d_reg)
		: osc_tick;

	// Main sequence
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I)
			state_reg <= ST_RESET;
		else if (!req_n_s)
			state_reg <= ST_RESET;
		else
		begin
			unique case (state_reg)
				ST_RESET:
					if (status_s)
						state_reg <= ST_CONFIG;
				ST_CONFIG:
					if (FRAME_ERROR_I)
						state_reg <= ST_ERROR;
					else if (DATA_COMPLETE_I && done_s)
						state_reg <= ST_INIT;
				ST_ERROR:
					if (opts_reg.auto_restart &&
						tmo_reg >= CNT_W'(RESTART_CYCLES - 1))
						state_reg <= ST_RESET;
				ST_INIT:
					if (init_tick && cnt_last(init_reg, INIT_COUNT))
						state_reg <= ST_USER;
				ST_USER:
					state_reg <= ST_USER;
				default:
					state_reg <= ST_RESET;
			endcase
		end
	end

	// Error time-out; without auto restart only a request clears it
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I || state_reg != ST_ERROR)
			tmo_reg <= CNT_ZERO;
		else if (tmo_reg != {CNT_W{1'b1}})
			tmo_reg <= tmo_reg + CNT_ONE;
	end

	// Init counter cleared outside init
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I || state_reg != ST_INIT)
			init_reg <= CNT_ZERO;
		else if (init_tick)
			init_reg <= init_reg + CNT_ONE;
	end

	// Options latched at first frame
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I || state_reg == ST_RESET)
		begin
			opts_reg <= '0;
			first_frame_reg <= 1'b1;
		end
		else if (first_hit)
		begin
			opts_reg <= OPTS_I;
			first_frame_reg <= 1'b0;
		end
	end

	// Init pin pulled low from first frame to user mode
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I || state_reg == ST_RESET || state_reg == ST_USER)
			init_low_reg <= 1'b0;
		else if (first_hit)
			init_low_reg <= OPTS_I.init_out_en;
	end

	// Status follows the synced request, so a held request keeps it low
	always_comb
	begin
		pins.status_oe = !req_n_s;
		pins.done_oe = 1'h0;
		// Register clears an edge late; mask so release lands with user mode
		pins.init_oe = init_low_reg && (state_reg != ST_USER);
		unique case (state_reg)
			ST_RESET:
				pins.done_oe = 1'h1;
			ST_CONFIG:
				pins.done_oe = !DATA_COMPLETE_I;
			ST_ERROR:
			begin
				pins.status_oe = 1'h1;
				pins.done_oe = 1'h1;
			end
			ST_INIT, ST_USER:
				pins.done_oe = 1'h0;
			default:
				pins.done_oe = 1'h1;
		endcase
	end

	// Open-drain: drive low only when enabled
	assign STATUS_N_O = 1'b0;
	assign STATUS_N_OE_O = pins.status_oe;
	assign CONFIG_DONE_O = 1'b0;
	assign CONFIG_DONE_OE_O = pins.done_oe;
	assign INIT_COMPLETE_O = 1'b0;
	assign INIT_COMPLETE_OE_O = pins.init_oe;
	assign IO_ENABLE_O = (state_reg == ST_USER);
	assign CONFIG_ACTIVE_O = (state_reg == ST_CONFIG);
	assign USER_MODE_O = (state_reg == ST_USER);
endmodule : crc_ctrl

// file: test/crc_ctrl_assertions.sv
// Checker for the restart and initialization controller.
// Assumes RESTART_CYCLES 20 and INIT_COUNT 8 in simulation.
`timescale 1ns/1ps
module crc_ctrl_assertions
	import crc_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CONFIG_REQUEST_N_I,
	input wire logic STATUS_N_I,
	input wire logic FRAME_ERROR_I,
	input wire crc_pkg::crc_opts_s OPTS_I,
	input wire logic STATUS_N_OE_O,
	input wire logic CONFIG_DONE_OE_O,
	input wire logic INIT_COMPLETE_OE_O,
	input wire logic IO_ENABLE_O,
	input wire logic CONFIG_ACTIVE_O,
	input wire logic USER_MODE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	property p_req;
		!CONFIG_REQUEST_N_I [*4] |=>
			STATUS_N_OE_O && CONFIG_DONE_OE_O && !IO_ENABLE_O;
	endproperty
	a_req: assert property (p_req) else $error("request ignored");
	property p_cfg;
		$rose(CONFIG_ACTIVE_O) |->
			$past(CONFIG_REQUEST_N_I, 2) && $past(STATUS_N_I, 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("early config");
	property p_err;
		CONFIG_ACTIVE_O && FRAME_ERROR_I |=>
			STATUS_N_OE_O && CONFIG_DONE_OE_O;
	endproperty
	a_err: assert property (p_err) else $error("error not flagged");
	property p_auto;
		CONFIG_ACTIVE_O && FRAME_ERROR_I && OPTS_I.auto_restart |->
			##[2:26] !STATUS_N_OE_O;
	endproperty
	a_auto: assert property (p_auto) else $error("no auto release");
	property p_hold;
		CONFIG_ACTIVE_O && FRAME_ERROR_I && !OPTS_I.auto_restart
			##1 CONFIG_REQUEST_N_I [*8] |-> STATUS_N_OE_O;
	endproperty
	a_hold: assert property (p_hold) else $error("error released");
	property p_early;
		$fell(CONFIG_ACTIVE_O) && !STATUS_N_OE_O |-> !USER_MODE_O [*8];
	endproperty
	a_early: assert property (p_early) else $error("user too early");
	property p_osc;
		$fell(CONFIG_ACTIVE_O) && !STATUS_N_OE_O && !OPTS_I.user_clk_en
			|-> ##[14:24] USER_MODE_O;
	endproperty
	a_osc: assert property (p_osc) else $error("init stalled");
	property p_ic;
		USER_MODE_O |-> !INIT_COMPLETE_OE_O && IO_ENABLE_O;
	endproperty
	a_ic: assert property (p_ic) else $error("init pin held");
	cover property ($rose(USER_MODE_O));
	cover property (CONFIG_ACTIVE_O && FRAME_ERROR_I);
	cover property (!CONFIG_REQUEST_N_I [*4]);
endmodule : crc_ctrl_assertions

bind crc_ctrl crc_ctrl_assertions crc_ctrl_assertions_inst (.*);

// file: test/crc_host.sv
// Host model: request pin, pulled-up wired lines, user clock.
// Assumes tb calls pulse at a falling edge.
`timescale 1ns/1ps
module crc_host (
	input wire logic clk_i,
	input wire logic uclk_en_i,
	input wire logic stat_oe_i,
	input wire logic done_oe_i,
	output logic config_request_n_o = 1'h1,
	output logic status_n_o,
	output logic config_done_o,
	output logic user_init_clock_o = 1'h0
);
	// Pull-ups, only this device pulls low
	assign status_n_o = !stat_oe_i;
	assign config_done_o = !done_oe_i;
	// Stands still when withheld
	always @(negedge clk_i)
		if (uclk_en_i)
			user_init_clock_o <= !user_init_clock_o;
	// 600 ns, margin over the minimum
	task pulse;
		config_request_n_o = 1'h0;
		repeat (12) @(negedge clk_i);
		config_request_n_o = 1'h1;
	endtask : pulse
endmodule : crc_host

// file: test/tb.sv
// Testbench for the restart and initialization controller.
// Assumes the host model in crc_host.sv and the bound checker.
`timescale 1ns/1ps
module tb;
	import crc_pkg::*;
	logic MCLK_I = 0, RST_I = 1, FRAME_VALID_I = 0, FRAME_ERROR_I = 0;
	logic DATA_COMPLETE_I = 0, uclk_en = 0, STATUS_N_O, CONFIG_DONE_O;
	logic CONFIG_REQUEST_N_I, STATUS_N_I, CONFIG_DONE_I, USER_INIT_CLOCK_I;
	logic STATUS_N_OE_O, CONFIG_DONE_OE_O, INIT_COMPLETE_O, IO_ENABLE_O;
	logic INIT_COMPLETE_OE_O, CONFIG_ACTIVE_O, USER_MODE_O;
	crc_opts_s OPTS_I = 3'h0;
	int miscompares = 0, checks = 0, n;
	always #25 MCLK_I = ~MCLK_I;
	crc_host crc_host_inst (.clk_i(MCLK_I), .uclk_en_i(uclk_en),
		.stat_oe_i(STATUS_N_OE_O), .done_oe_i(CONFIG_DONE_OE_O),
		.config_request_n_o(CONFIG_REQUEST_N_I), .status_n_o(STATUS_N_I),
		.config_done_o(CONFIG_DONE_I), .user_init_clock_o(USER_INIT_CLOCK_I));
	crc_ctrl #(.RESTART_CYCLES(20), .INIT_COUNT(8)) crc_ctrl_inst (.*);
	task ck(input string s, input logic g, input logic e);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s exp %b got %b", s, e, g);
		end
	endtask : ck
	task end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task frame(input crc_opts_s o);
		OPTS_I = o;
		FRAME_VALID_I = 1;
		@(negedge MCLK_I);
		FRAME_VALID_I = 0;
	endtask : frame
	task t_req;
		DATA_COMPLETE_I = 0;
		fork crc_host_inst.pulse(); join_none
		repeat (6) @(negedge MCLK_I);
		ck("status_oe", STATUS_N_OE_O, 1);
		ck("done_oe", CONFIG_DONE_OE_O, 1);
		ck("io_en", IO_ENABLE_O, 0);
		ck("od_data", STATUS_N_O | CONFIG_DONE_O | INIT_COMPLETE_O, 0);
		ck("cfg_low", CONFIG_ACTIVE_O, 0);
		repeat (40) if (!CONFIG_ACTIVE_O) @(negedge MCLK_I);
		ck("cfg", CONFIG_ACTIVE_O, 1);
	endtask : t_req
	task t_run(input crc_opts_s o);
		frame(o);
		ck("init_oe", INIT_COMPLETE_OE_O, o.init_out_en);
		DATA_COMPLETE_I = 1;
		n = 0;
		while (!USER_MODE_O && n < 99)
		begin
			@(negedge MCLK_I);
			n++;
		end
		ck("user", USER_MODE_O, 1);
		ck("count", n >= 16, 1);
		ck("io_en", IO_ENABLE_O, 1);
		ck("init_rel", INIT_COMPLETE_OE_O, 0);
	endtask : t_run
	task t_err(input logic a);
		frame({a, 2'h0});
		FRAME_ERROR_I = 1;
		@(negedge MCLK_I);
		FRAME_ERROR_I = 0;
		ck("err_st", STATUS_N_OE_O, 1);
		ck("err_dn", CONFIG_DONE_OE_O, 1);
		repeat (30) @(negedge MCLK_I);
		ck("retry", CONFIG_ACTIVE_O, a);
	endtask : t_err
	task t_uclk;
		t_req;
		frame(3'h2);
		DATA_COMPLETE_I = 1;
		repeat (40) @(negedge MCLK_I);
		ck("held", USER_MODE_O, 0);
		uclk_en = 1;
		repeat (8) @(negedge MCLK_I);
		t_req;
		t_run(3'h2);
	endtask : t_uclk
	initial
	begin
		repeat (6) @(negedge MCLK_I);
		RST_I = 0;
		t_req;
		t_run(3'h1);
		t_req;
		t_err(1);
		t_req;
		t_err(0);
		t_uclk;
		end_of_test;
	end
	// Whole run is about 250 cycles
	initial
	begin
		repeat (3000) @(posedge MCLK_I);
		miscompares++;
		end_of_test;
	end
endmodule : tb
